//--- rtl/ddipc_code_map.sv
// maps an offset binary sample onto primary and complementary sink codes
`timescale 1ns/1ns
`include "ddipc_defs.svh"
module ddipc_code_map (
   input wire logic [15:0] sample,
   output logic [15:0] primary_sink,
   output logic [15:0] complement_sink
);
   // sink magnitude: full scale at code 0, none at all ones
   always_comb begin
      primary_sink = `DDIPC_ZERO_SINK_CODE - sample;
      complement_sink = sample;
   end
endmodule

//--- rtl/ddipc_defs.svh
// constant definitions for the dual converter input port control block
`ifndef DDIPC_DEFS_SVH
`define DDIPC_DEFS_SVH

`define DDIPC_BYTE_W 8
`define DDIPC_SAMPLE_W 16
`define DDIPC_BYTES_PER_FRAME 4
`define DDIPC_FULL_SCALE_CODE 16'h0000
`define DDIPC_ZERO_SINK_CODE 16'hFFFF
`define DDIPC_SAMPLE_RESET 16'h0000
`define DDIPC_DIV_RESET 4'h0
`define DDIPC_DIV_W 4
`define DDIPC_REVERSE_RESET 1'b0
`define DDIPC_EXTREF_RESET 1'b0
`define DDIPC_FOUR_WIRE_RESET 1'b0

`endif

//--- rtl/ddipc_pkg.sv
// types shared by the input port control block
package ddipc_pkg;
   typedef enum logic [2:0] {
      DDIPC_HUNT = 3'b001,
      DDIPC_COLLECT = 3'b010,
      DDIPC_GATED = 3'b100
   } ddipc_state_t;
endpackage

//--- rtl/ddipc_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
module ddipc_sync2 #(
   parameter logic INIT = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic meta_ff;
   logic hold_ff;
   logic nxt_meta;
   logic nxt_hold;

   always_comb begin
      nxt_meta = d;
      nxt_hold = meta_ff;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= INIT;
         hold_ff <= INIT;
      end else begin
         meta_ff <= nxt_meta;
         hold_ff <= nxt_hold;
      end
   end

   assign q = hold_ff;
endmodule

//--- rtl/ddipc_top.sv
// input port control of a dual 16-bit converter: capture, framing, gating, pin modes
//
// Notes on behaviour
// - data bus is sampled on both data clock edges, two bytes per cycle
// - frame marker sampled on data clock rising edge marks frame start
// - captured frame marker also resets the input byte buffer
// - bit line 7 is most significant, line 0 least, by default
// - offset binary: code 0 sinks full scale, all ones sinks nothing on primary
// - complementary output behaves opposite to the primary output
// - strobe sampled on core clock rising edge resets the clock dividers
// - whole chip resets while active-low chip reset is low
// - transmit gate low forces datapath to zero and ignores input data
// - reference select one takes external reference, zero drives internal one
// - serial data pin is bidirectional in three pin mode only, never driven in four pin mode
// - two 16-bit samples travel byte-wide interleaved, framed by frame marker
// - a configuration bit reverses the input bus bit order
// - four-wire select makes the alarm pin the serial data output
`timescale 1ns/1ns
`include "ddipc_defs.svh"
module ddipc_top
   import ddipc_pkg::*;
#(
   parameter int BYTE_W = `DDIPC_BYTE_W,
   parameter int DIV_W = `DDIPC_DIV_W
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [7:0] SOURCE_DATA_POS,
   input wire logic SOURCE_DATA_CLOCK_POS,
   input wire logic FRAME_MARKER_POS,
   input wire logic DIVIDER_SYNC_STROBE_POS,
   input wire logic CHIP_RESET_N,
   input wire logic TRANSMIT_GATE,
   input wire logic BUS_REVERSE,
   input wire logic EXTERNAL_REF_SELECT,
   input wire logic FOUR_WIRE_SERIAL_SELECT,
   input wire logic SERIAL_SELECT_N,
   input wire logic SERIAL_DATA_OUT_BIT,
   input wire logic ALARM_LEVEL,
   output logic [15:0] CHAN_A_PRIMARY_OUT,
   output logic [15:0] CHAN_A_COMPLEMENT_OUT,
   output logic [15:0] CHAN_B_PRIMARY_OUT,
   output logic [15:0] CHAN_B_COMPLEMENT_OUT,
   output logic SAMPLE_VALID,
   output logic FRAME_FIFO_RESET,
   output logic [DIV_W-1:0] CORE_DIVIDER,
   output logic REFERENCE_PIN_OE,
   output logic REFERENCE_EXTERNAL,
   output logic SERIAL_DATA_OE,
   output logic ALARM_OR_SERIAL_OUT
);
   // ***************************************************************
   // pin sampling
   // ***************************************************************
   // the source clock is oversampled on CLOCK; data, data clock, frame, strobe, gate, chip reset and serial select pins see two flops first
   logic [BYTE_W-1:0] data_s;
   logic dclk_s;
   logic frame_s;
   logic strobe_s;
   logic gate_s;
   logic chip_rst_n_s;
   logic sel_n_s;

   genvar gi;
   generate
      for (gi = 0; gi < BYTE_W; gi++) begin : g_dsync
         ddipc_sync2 u_sync (
            .clk(CLOCK),
            .rst(RST),
            .d(SOURCE_DATA_POS[gi]),
            .q(data_s[gi])
         );
      end
   endgenerate

   ddipc_sync2 u_dclk (.clk(CLOCK), .rst(RST), .d(SOURCE_DATA_CLOCK_POS), .q(dclk_s));
   ddipc_sync2 u_frame (.clk(CLOCK), .rst(RST), .d(FRAME_MARKER_POS), .q(frame_s));
   ddipc_sync2 u_strobe (.clk(CLOCK), .rst(RST), .d(DIVIDER_SYNC_STROBE_POS), .q(strobe_s));
   ddipc_sync2 u_gate (.clk(CLOCK), .rst(RST), .d(TRANSMIT_GATE), .q(gate_s));
   ddipc_sync2 #(.INIT(1'b1)) u_crst (
      .clk(CLOCK),
      .rst(RST),
      .d(CHIP_RESET_N),
      .q(chip_rst_n_s)
   );
   ddipc_sync2 #(.INIT(1'b1)) u_sel (.clk(CLOCK), .rst(RST), .d(SERIAL_SELECT_N), .q(sel_n_s));

   // ***************************************************************
   // local reset and edge detection
   // ***************************************************************
   logic core_rst;
   logic dclk_d_ff;
   logic strobe_d_ff;
   logic nxt_dclk_d;
   logic nxt_strobe_d;
   logic dclk_rise;
   logic dclk_fall;
   logic strobe_rise;

   assign core_rst = RST | ~chip_rst_n_s;

   always_comb begin
      nxt_dclk_d = dclk_s;
      nxt_strobe_d = strobe_s;
   end

   always_ff @(posedge CLOCK) begin
      if (core_rst) begin
         dclk_d_ff <= 1'b0;
         strobe_d_ff <= 1'b0;
      end else begin
         dclk_d_ff <= nxt_dclk_d;
         strobe_d_ff <= nxt_strobe_d;
      end
   end

   assign dclk_rise = dclk_s & ~dclk_d_ff;
   assign dclk_fall = ~dclk_s & dclk_d_ff;
   assign strobe_rise = strobe_s & ~strobe_d_ff;

   // bit order: line 7 is msb unless reversed
   function automatic logic [BYTE_W-1:0] order_byte(input logic [BYTE_W-1:0] b,
                                                    input logic rev);
      logic [BYTE_W-1:0] r;
      r = '0;
      for (int i = 0; i < BYTE_W; i++) begin
         r[i] = rev ? b[BYTE_W-1-i] : b[i];
      end
      return r;
   endfunction

   // ***************************************************************
   // byte capture and framing
   // ***************************************************************
   ddipc_state_t state_ff;
   ddipc_state_t nxt_state;
   logic [1:0] idx_ff;
   logic [1:0] nxt_idx;
   logic [7:0] byte_ff [0:3];
   logic [7:0] nxt_byte [0:3];
   logic [15:0] samp_a_ff;
   logic [15:0] samp_b_ff;
   logic [15:0] nxt_samp_a;
   logic [15:0] nxt_samp_b;
   logic valid_ff;
   logic nxt_valid;
   logic fifo_rst_ff;
   logic nxt_fifo_rst;
   logic take;
   logic [7:0] cur_byte;
   logic [15:0] nxt_a_pri;
   logic [15:0] nxt_a_cmp;
   logic [15:0] nxt_b_pri;
   logic [15:0] nxt_b_cmp;
   logic [15:0] a_pri_ff;
   logic [15:0] a_cmp_ff;
   logic [15:0] b_pri_ff;
   logic [15:0] b_cmp_ff;

   assign take = dclk_rise | dclk_fall;
   assign cur_byte = order_byte(data_s, BUS_REVERSE);

   always_comb begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_samp_a = samp_a_ff;
      nxt_samp_b = samp_b_ff;
      nxt_valid = 1'b0;
      nxt_fifo_rst = 1'b0;
      for (int k = 0; k < 4; k++) begin
         nxt_byte[k] = byte_ff[k];
      end
      case (state_ff)
         DDIPC_GATED: begin
            nxt_samp_a = `DDIPC_SAMPLE_RESET;
            nxt_samp_b = `DDIPC_SAMPLE_RESET;
            nxt_idx = 2'h0;
            if (gate_s) begin
               nxt_state = DDIPC_HUNT;
            end
         end
         DDIPC_HUNT: begin
            // frame only counts when seen on a rising source edge
            if (dclk_rise && frame_s) begin
               nxt_byte[0] = cur_byte;
               nxt_idx = 2'h1;
               nxt_fifo_rst = 1'b1;
               nxt_state = DDIPC_COLLECT;
            end
         end
         DDIPC_COLLECT: begin
            if (dclk_rise && frame_s) begin
               // a fresh frame restarts the group and flushes the buffer
               nxt_byte[0] = cur_byte;
               nxt_idx = 2'h1;
               nxt_fifo_rst = 1'b1;
            end else if (take) begin
               nxt_byte[idx_ff] = cur_byte;
               nxt_idx = 2'(idx_ff + 2'h1);
               if (idx_ff == 2'h3) begin
                  // order a-msb, a-lsb, b-msb, b-lsb
                  nxt_samp_a = {byte_ff[0], byte_ff[1]};
                  nxt_samp_b = {byte_ff[2], cur_byte};
                  nxt_valid = 1'b1;
                  nxt_state = DDIPC_HUNT;
               end
            end
         end
         default: begin
            nxt_state = DDIPC_GATED;
         end
      endcase
      if (!gate_s) begin
         nxt_state = DDIPC_GATED;
         nxt_samp_a = `DDIPC_SAMPLE_RESET;
         nxt_samp_b = `DDIPC_SAMPLE_RESET;
         nxt_valid = 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (core_rst) begin
         state_ff <= DDIPC_GATED;
         idx_ff <= 2'h0;
         samp_a_ff <= `DDIPC_SAMPLE_RESET;
         samp_b_ff <= `DDIPC_SAMPLE_RESET;
         valid_ff <= 1'b0;
         fifo_rst_ff <= 1'b0;
         a_pri_ff <= `DDIPC_ZERO_SINK_CODE;
         a_cmp_ff <= `DDIPC_SAMPLE_RESET;
         b_pri_ff <= `DDIPC_ZERO_SINK_CODE;
         b_cmp_ff <= `DDIPC_SAMPLE_RESET;
         for (int k = 0; k < 4; k++) begin
            byte_ff[k] <= 8'h00;
         end
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         samp_a_ff <= nxt_samp_a;
         samp_b_ff <= nxt_samp_b;
         valid_ff <= nxt_valid;
         fifo_rst_ff <= nxt_fifo_rst;
         a_pri_ff <= nxt_a_pri;
         a_cmp_ff <= nxt_a_cmp;
         b_pri_ff <= nxt_b_pri;
         b_cmp_ff <= nxt_b_cmp;
         for (int k = 0; k < 4; k++) begin
            byte_ff[k] <= nxt_byte[k];
         end
      end
   end

   // ***************************************************************
   // divider resynchronisation
   // ***************************************************************
   logic [DIV_W-1:0] div_ff;
   logic [DIV_W-1:0] nxt_div;

   always_comb begin
      if (strobe_rise) begin
         nxt_div = `DDIPC_DIV_RESET;
      end else begin
         nxt_div = DIV_W'(div_ff + 1'b1);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (core_rst) begin
         div_ff <= `DDIPC_DIV_RESET;
      end else begin
         div_ff <= nxt_div;
      end
   end

   // ***************************************************************
   // output codes and pin modes
   // ***************************************************************
   // mapped from the next sample so the output pins come straight from flops
   ddipc_code_map u_map_a (
      .sample(nxt_samp_a),
      .primary_sink(nxt_a_pri),
      .complement_sink(nxt_a_cmp)
   );

   ddipc_code_map u_map_b (
      .sample(nxt_samp_b),
      .primary_sink(nxt_b_pri),
      .complement_sink(nxt_b_cmp)
   );

   logic ref_ext_ff;
   logic sdo_ff;
   logic sdio_oe_ff;
   logic nxt_ref_ext;
   logic nxt_sdo;
   logic nxt_sdio_oe;

   always_comb begin
      nxt_ref_ext = EXTERNAL_REF_SELECT;
      // serial select is only ever read, never driven
      nxt_sdio_oe = ~sel_n_s & ~FOUR_WIRE_SERIAL_SELECT;
      nxt_sdo = FOUR_WIRE_SERIAL_SELECT ? SERIAL_DATA_OUT_BIT : ALARM_LEVEL;
   end

   always_ff @(posedge CLOCK) begin
      if (core_rst) begin
         ref_ext_ff <= `DDIPC_EXTREF_RESET;
         sdo_ff <= 1'b0;
         sdio_oe_ff <= 1'b0;
      end else begin
         ref_ext_ff <= nxt_ref_ext;
         sdo_ff <= nxt_sdo;
         sdio_oe_ff <= nxt_sdio_oe;
      end
   end

   assign SAMPLE_VALID = valid_ff;
   assign FRAME_FIFO_RESET = fifo_rst_ff;
   assign CHAN_A_PRIMARY_OUT = a_pri_ff;
   assign CHAN_A_COMPLEMENT_OUT = a_cmp_ff;
   assign CHAN_B_PRIMARY_OUT = b_pri_ff;
   assign CHAN_B_COMPLEMENT_OUT = b_cmp_ff;
   assign CORE_DIVIDER = div_ff;
   assign REFERENCE_EXTERNAL = ref_ext_ff;
   assign REFERENCE_PIN_OE = ~ref_ext_ff;
   assign SERIAL_DATA_OE = sdio_oe_ff;
   assign ALARM_OR_SERIAL_OUT = sdo_ff;
endmodule

//--- tb/ddipc_checker.sv
// port-level assertions for the input port control block
`timescale 1ns/1ns
module ddipc_checker
   import ddipc_pkg::*;
#(
   parameter int DIV_W = 4
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic SOURCE_DATA_CLOCK_POS,
   input wire logic FRAME_MARKER_POS,
   input wire logic DIVIDER_SYNC_STROBE_POS,
   input wire logic CHIP_RESET_N,
   input wire logic TRANSMIT_GATE,
   input wire logic EXTERNAL_REF_SELECT,
   input wire logic FOUR_WIRE_SERIAL_SELECT,
   input wire logic SERIAL_DATA_OUT_BIT,
   input wire logic ALARM_LEVEL,
   input wire logic [15:0] CHAN_A_PRIMARY_OUT,
   input wire logic [15:0] CHAN_A_COMPLEMENT_OUT,
   input wire logic SAMPLE_VALID,
   input wire logic FRAME_FIFO_RESET,
   input wire logic [DIV_W-1:0] CORE_DIVIDER,
   input wire logic REFERENCE_EXTERNAL,
   input wire logic SERIAL_DATA_OE,
   input wire logic ALARM_OR_SERIAL_OUT
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   // ********************************
   // settled after any reset
   // ********************************
   // chip reset is synchronised, so reference and alarm outputs are only judged after a quiet spell
   logic [2:0] calm_ff;
   logic [2:0] nxt_calm;
   always_comb begin
      nxt_calm = (RST || !CHIP_RESET_N) ? 3'h0 : calm_ff + {2'h0, calm_ff != 3'h7};
   end
   always_ff @(posedge CLOCK) begin
      calm_ff <= nxt_calm;
   end
   sequence strobe_rise;
      !DIVIDER_SYNC_STROBE_POS ##1 DIVIDER_SYNC_STROBE_POS;
   endsequence
   sequence gate_off;
      !TRANSMIT_GATE [*4];
   endsequence
   sequence chip_held;
      !CHIP_RESET_N [*4];
   endsequence
   a_out_inverse: assert property (CHAN_A_PRIMARY_OUT == ~CHAN_A_COMPLEMENT_OUT)
      else $error("outputs not complementary");
   a_ref_follow: assert property (calm_ff == 3'h7 |->
      REFERENCE_EXTERNAL == $past(EXTERNAL_REF_SELECT))
      else $error("reference mode stale");
   a_alarm_mux: assert property (calm_ff == 3'h7 |->
      ALARM_OR_SERIAL_OUT == ($past(FOUR_WIRE_SERIAL_SELECT)
      ? $past(SERIAL_DATA_OUT_BIT) : $past(ALARM_LEVEL)))
      else $error("alarm pin source wrong");
   a_four_wire_quiet: assert property ($past(FOUR_WIRE_SERIAL_SELECT) |-> !SERIAL_DATA_OE)
      else $error("data pin driven in four wire mode");
   a_frame_cause: assert property (FRAME_FIFO_RESET |->
      $past(FRAME_MARKER_POS, 3) && $past(SOURCE_DATA_CLOCK_POS, 3))
      else $error("fifo reset without framed edge");
   a_fifo_pulse: assert property (FRAME_FIFO_RESET |=> !FRAME_FIFO_RESET)
      else $error("fifo reset longer than one cycle");
   a_valid_pulse: assert property (SAMPLE_VALID |=> !SAMPLE_VALID)
      else $error("sample valid longer than one cycle");
   a_gate_zero: assert property (gate_off |->
      CHAN_A_COMPLEMENT_OUT == 16'h0000 && !SAMPLE_VALID)
      else $error("data passed while gated");
   a_chip_reset: assert property (chip_held |->
      CHAN_A_PRIMARY_OUT == 16'hFFFF && CORE_DIVIDER == '0)
      else $error("chip reset not applied");
   a_strobe_zero: assert property (strobe_rise |-> ##[1:4] CORE_DIVIDER == '0)
      else $error("divider not cleared by strobe");
endmodule
bind ddipc_top ddipc_checker #(.DIV_W(DIV_W)) u_chk (.*);

//--- tb/ddipc_src_model.sv
// upstream transmitter model: bytes, frame marker and data clock
`timescale 1ns/1ns
module ddipc_src_model (
   input wire logic clk,
   output logic [7:0] data,
   output logic dclk,
   output logic frame
);
   initial begin
      data = 8'h00;
      dclk = 1'b0;
      frame = 1'b0;
   end
   // ********************************
   // frame transmit
   // ********************************
   // data clock halts low between frames; each half lasts three core cycles
   task automatic send(input logic [31:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         data = w[31-8*i -: 8];
         frame = (i == 0);
         dclk = ~dclk;
         repeat (2) @(negedge clk);
      end
      @(negedge clk);
      // lines are unterminated once released: show the inverse, never the old value
      data = ~data;
      frame = ~frame;
   endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the input port control block
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
   import ddipc_pkg::*;
   logic CLOCK, RST, SOURCE_DATA_CLOCK_POS, FRAME_MARKER_POS, DIVIDER_SYNC_STROBE_POS;
   logic CHIP_RESET_N, TRANSMIT_GATE, BUS_REVERSE, EXTERNAL_REF_SELECT, SERIAL_SELECT_N;
   logic FOUR_WIRE_SERIAL_SELECT, SERIAL_DATA_OUT_BIT, ALARM_LEVEL, SAMPLE_VALID;
   logic FRAME_FIFO_RESET, REFERENCE_PIN_OE, REFERENCE_EXTERNAL, SERIAL_DATA_OE;
   logic ALARM_OR_SERIAL_OUT;
   logic [7:0] SOURCE_DATA_POS;
   logic [15:0] CHAN_A_PRIMARY_OUT, CHAN_A_COMPLEMENT_OUT, CHAN_B_PRIMARY_OUT;
   logic [15:0] CHAN_B_COMPLEMENT_OUT;
   logic [3:0] CORE_DIVIDER;
   int errors = 0, check_count = 0, nvalid = 0, nfifo = 0, n;
   ddipc_top u_dut (.*);
   ddipc_src_model u_src (.clk(CLOCK), .data(SOURCE_DATA_POS),
      .dclk(SOURCE_DATA_CLOCK_POS), .frame(FRAME_MARKER_POS));
   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   always @(negedge CLOCK) begin
      nvalid += (SAMPLE_VALID === 1'b1);
      nfifo += (FRAME_FIFO_RESET === 1'b1);
   end
   // ********************************
   // helpers
   // ********************************
   task automatic results;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [31:0] rv(input logic [31:0] w);
      for (int i = 0; i < 32; i++) rv[i] = w[(i/8)*8+7-i%8];
   endfunction
   // optional cut: a two-byte stub first, which the new frame must discard
   task automatic frame(input logic [31:0] w, input logic [31:0] e, input bit cut);
      int n0;
      n0 = nvalid;
      if (cut) u_src.send(~w, 2);
      u_src.send(w, 4);
      for (int k = 0; k < 20 && nvalid == n0; k++) @(negedge CLOCK);
      `CHK(nvalid, n0 + 1)
      if (nvalid == n0) results();
      `CHK(CHAN_A_COMPLEMENT_OUT, e[31:16])
      `CHK(CHAN_B_COMPLEMENT_OUT, e[15:0])
      `CHK(CHAN_A_PRIMARY_OUT, ~e[31:16])
      `CHK(CHAN_B_PRIMARY_OUT, ~e[15:0])
   endtask
   // ********************************
   // main sequence
   // ********************************
   initial begin
      {RST, CHIP_RESET_N, TRANSMIT_GATE, SERIAL_SELECT_N} = 4'hF;
      {DIVIDER_SYNC_STROBE_POS, BUS_REVERSE, EXTERNAL_REF_SELECT} = 3'h0;
      {FOUR_WIRE_SERIAL_SELECT, SERIAL_DATA_OUT_BIT, ALARM_LEVEL} = 3'h0;
      repeat (6) @(negedge CLOCK);
      RST = 1'b0;
      repeat (6) @(negedge CLOCK);
      frame(32'h0000_FFFF, 32'h0000_FFFF, 0);
      frame(32'h8001_7E5A, 32'h8001_7E5A, 1);
      BUS_REVERSE = 1'b1;
      frame(32'h8001_7E5A, rv(32'h8001_7E5A), 0);
      BUS_REVERSE = 1'b0;
      `CHK(nfifo, 4)
      TRANSMIT_GATE = 1'b0;
      repeat (4) @(negedge CLOCK);
      `CHK(CHAN_A_COMPLEMENT_OUT, 16'h0000)
      n = nvalid;
      u_src.send(32'h1234_5678, 4);
      repeat (8) @(negedge CLOCK);
      `CHK(nvalid, n)
      TRANSMIT_GATE = 1'b1;
      repeat (6) @(negedge CLOCK);
      frame(32'h1234_5678, 32'h1234_5678, 0);
      CHIP_RESET_N = 1'b0;
      @(negedge CLOCK);
      `CHK(CHAN_A_COMPLEMENT_OUT, 16'h1234)
      repeat (8) @(negedge CLOCK);
      `CHK(CHAN_B_PRIMARY_OUT, 16'hFFFF)
      CHIP_RESET_N = 1'b1;
      repeat (8) @(negedge CLOCK);
      frame(32'hFFFF_0000, 32'hFFFF_0000, 0);
      DIVIDER_SYNC_STROBE_POS = 1'b1;
      repeat (4) @(negedge CLOCK);
      // two sync flops and the edge detect put the zero three edges in, then one count
      `CHK(CORE_DIVIDER, 4'h1)
      DIVIDER_SYNC_STROBE_POS = 1'b0;
      for (int i = 0; i < 8; i++) begin
         {SERIAL_SELECT_N, FOUR_WIRE_SERIAL_SELECT, EXTERNAL_REF_SELECT} = i[2:0];
         SERIAL_DATA_OUT_BIT = i[0];
         ALARM_LEVEL = ~i[0];
         repeat (5) @(negedge CLOCK);
         `CHK(REFERENCE_PIN_OE, ~i[0])
         `CHK(REFERENCE_EXTERNAL, i[0])
         `CHK(SERIAL_DATA_OE, ~i[2] & ~i[1])
         `CHK(ALARM_OR_SERIAL_OUT, i[1] ? i[0] : ~i[0])
      end
      results();
   end
endmodule
